// >>> txmod_pkg.sv
// Package with register map, field layout, reset values and timing codes
`default_nettype none
package txmod_pkg;
   // Register word indices (index = printed offset, byte address = 4 * index)
   localparam logic [7:0] AUX_MOD_IDX  = 8'h28;
   localparam logic [7:0] PASV_RES_IDX = 8'h29;
   localparam logic [7:0] DRV_TIM_IDX  = 8'h2a;
   localparam logic [7:0] AM_IDX_IDX   = 8'h2b;
   localparam logic [7:0] RAM_CODE_IDX = 8'h2c;
   localparam logic [7:0] STATUS_IDX   = 8'h2d;
   localparam logic [9:0] AUX_MOD_ADDR  = {AUX_MOD_IDX, 2'b00};
   localparam logic [9:0] PASV_RES_ADDR = {PASV_RES_IDX, 2'b00};
   localparam logic [9:0] DRV_TIM_ADDR  = {DRV_TIM_IDX, 2'b00};
   localparam logic [9:0] AM_IDX_ADDR   = {AM_IDX_IDX, 2'b00};
   localparam logic [9:0] RAM_CODE_ADDR = {RAM_CODE_IDX, 2'b00};
   localparam logic [9:0] STATUS_ADDR   = {STATUS_IDX, 2'b00};
   // Field positions
   localparam int REG_AM_OFF_BIT  = 7;
   localparam int EXT_POL_BIT     = 6;
   localparam int EXT_EN_BIT      = 5;
   localparam int DRV_LM_BIT      = 4;
   localparam int RESIST_AM_BIT   = 3;
   localparam int TIM_MAN_BIT     = 3;
   // Reset values
   localparam logic [7:0] AUX_MOD_RST  = 8'h10;
   localparam logic [7:0] AUX_MOD_MASK = 8'hf8;
   localparam logic [7:0] PASV_RES_RST = 8'h70;
   localparam logic [7:0] DRV_TIM_RST  = 8'h7c;
   localparam logic [3:0] AM_IDX_RST   = 4'h7;
   localparam logic [6:0] RAM_CODE_RST = 7'h00;
   // Shared 4-bit resistance code: 4'hf puts the driver in high impedance
   localparam logic [3:0] RES_HIGH_Z   = 4'hf;
   // Transient speed steps, slowest first
   localparam logic [2:0] SPD_SLOW     = 3'h0;
   localparam logic [2:0] SPD_FAST     = 3'h4;
   localparam int         AUTO_MAX_RF  = 10;
endpackage
`default_nettype wire

// >>> txmod_auto_timing.sv
// Automatic driver transient search over RF periods
`default_nettype none
module txmod_auto_timing (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic       start_i,
   input  wire logic [3:0] target_i,
   // Measurement, synchronous to clk_sys_i
   input  wire logic       rf_period_i,
   input  wire logic [3:0] ratio_i,
   // Result
   output logic     [2:0]  speed_o,
   output logic            busy_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_MEASURE} auto_state_t;
   auto_state_t state_q;
   logic [3:0]  rf_cnt_q;

   // Each step is judged at the end of one RF period, so five steps need at
   // most five periods, well inside the ten allowed
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_q  <= ST_IDLE;
         speed_o  <= txmod_pkg::SPD_SLOW;
         rf_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_i) begin
                  speed_o  <= txmod_pkg::SPD_SLOW; // R10
                  rf_cnt_q <= 4'h0;
                  state_q  <= ST_MEASURE;
               end
            end
            ST_MEASURE: begin
               if (rf_period_i) begin
                  rf_cnt_q <= rf_cnt_q + 4'h1;
                  if (ratio_i >= target_i || speed_o == txmod_pkg::SPD_FAST
                      || rf_cnt_q == 4'(txmod_pkg::AUTO_MAX_RF - 1)) begin
                     state_q <= ST_IDLE; // R11 R12
                  end else begin
                     speed_o <= speed_o + 3'h1; // R11
                  end
               end
            end
         endcase
      end
   end

   assign busy_o = (state_q == ST_MEASURE);

   property p_auto_bound;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      speed_o <= txmod_pkg::SPD_FAST;
   endproperty
   a_auto_bound: assert property (p_auto_bound) else $error("speed beyond five steps"); // R12

   property p_auto_start;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_q == ST_IDLE && start_i) |=> speed_o == txmod_pkg::SPD_SLOW && busy_o;
   endproperty
   a_auto_start: assert property (p_auto_start) else $error("search not from slowest"); // R10

   property p_auto_step;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (busy_o && rf_period_i && ratio_i < target_i && speed_o < txmod_pkg::SPD_FAST
       && rf_cnt_q < 4'h9) |=> speed_o == $past(speed_o) + 3'h1;
   endproperty
   a_auto_step: assert property (p_auto_step) else $error("no faster step below target"); // R11

   property p_auto_stop;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (busy_o && rf_period_i && ratio_i >= target_i) |=> !busy_o && $stable(speed_o);
   endproperty
   a_auto_stop: assert property (p_auto_stop) else $error("search not stopped at target"); // R11
endmodule
`default_nettype wire

// >>> txmod_config.sv
// Transmitter modulation and driver timing configuration bank on Wishbone
// Functional notes
// R1: Bit7 low enables regulator AM
// R2: Bit6 sets external pin polarity
// R3: Bit5 enables external load-modulation pin output
// R4: Bit4 driver load modulation, uses passive resistances
// R5: Bit3 enables resistive AM with code
// R6: Passive register: upper modulated, lower unmodulated
// R7: Shared code; 15 means high impedance
// R8: Software sets resistances before passive mode
// R9: Timing bits7:4 hold target ratio
// R10: Auto search starts from slowest transient
// R11: Step faster until target met
// R12: Five steps, done within ten periods
// R13: Bit3 picks manual or automatic timing
// R14: Manual code: 1xx decodes to fast
// R15: AM index selects regulator AM depth
// R16: Resistive AM code is seven bits
// R17: Reserved aux bits ignore writes, read zero
//
// Local design decision: the Wishbone register port.
`default_nettype none
module txmod_config (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Transmit state from the modulator core
   input  wire logic        mod_active_i,
   input  wire logic        passive_target_i,
   input  wire logic        auto_start_i,
   input  wire logic        rf_period_i,
   input  wire logic [3:0]  ratio_i,
   // Driver controls
   output logic             regulator_am_on_o,
   output logic      [3:0]  am_depth_index_o,
   output logic             resistive_am_on_o,
   output logic      [6:0]  resistive_am_code_o,
   output logic      [3:0]  driver_res_code_o,
   output logic             driver_high_z_o,
   output logic      [2:0]  driver_speed_o,
   output logic             ext_loadmod_pin_o
);
   logic [7:0] aux_mod_q;
   logic [7:0] pasv_res_q;
   logic [7:0] drv_tim_q;
   logic [3:0] am_idx_q;
   logic [6:0] ram_code_q;
   logic       hit_aux, hit_pt, hit_tim, hit_am, hit_ram, hit_stat, hit_any;
   logic       req;
   logic [2:0] auto_speed;
   logic       auto_busy;
   logic [2:0] manual_speed;
   logic [3:0] res_code_d;
   logic       loadmod_d;

   assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign hit_aux  = wb_adr_i == txmod_pkg::AUX_MOD_ADDR;
   assign hit_pt   = wb_adr_i == txmod_pkg::PASV_RES_ADDR;
   assign hit_tim  = wb_adr_i == txmod_pkg::DRV_TIM_ADDR;
   assign hit_am   = wb_adr_i == txmod_pkg::AM_IDX_ADDR;
   assign hit_ram  = wb_adr_i == txmod_pkg::RAM_CODE_ADDR;
   assign hit_stat = wb_adr_i == txmod_pkg::STATUS_ADDR;
   assign hit_any  = hit_aux | hit_pt | hit_tim | hit_am | hit_ram | hit_stat;

   // One-cycle answer; unmapped addresses get err so software sees the slip
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= req && hit_any;
         wb_err_o <= req && !hit_any;
      end
   end

   // Writes take only lane 0; registers are at most 8 bits wide (AM index 4, resistive AM code 7)
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         aux_mod_q  <= txmod_pkg::AUX_MOD_RST; // R4
         pasv_res_q <= txmod_pkg::PASV_RES_RST; // R6
         drv_tim_q  <= txmod_pkg::DRV_TIM_RST; // R9 R13 R14
         am_idx_q   <= txmod_pkg::AM_IDX_RST;
         ram_code_q <= txmod_pkg::RAM_CODE_RST;
      end else if (req && wb_we_i && wb_sel_i[0]) begin
         if (hit_aux) begin
            aux_mod_q <= wb_dat_i[7:0] & txmod_pkg::AUX_MOD_MASK; // R17
         end
         if (hit_pt) begin
            pasv_res_q <= wb_dat_i[7:0]; // R6
         end
         if (hit_tim) begin
            drv_tim_q <= wb_dat_i[7:0]; // R9
         end
         if (hit_am) begin
            am_idx_q <= wb_dat_i[3:0]; // R15
         end
         if (hit_ram) begin
            ram_code_q <= wb_dat_i[6:0]; // R16
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         unique case (1'b1)
            hit_aux:  wb_dat_o <= {24'h00_0000, aux_mod_q};
            hit_pt:   wb_dat_o <= {24'h00_0000, pasv_res_q};
            hit_tim:  wb_dat_o <= {24'h00_0000, drv_tim_q};
            hit_am:   wb_dat_o <= {28'h000_0000, am_idx_q};
            hit_ram:  wb_dat_o <= {25'h000_0000, ram_code_q};
            hit_stat: wb_dat_o <= {24'h00_0000, 4'h0, auto_busy, driver_speed_o};
            default:  wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   txmod_auto_timing u_auto (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .start_i     (auto_start_i),
      .target_i    (drv_tim_q[7:4]),
      .rf_period_i (rf_period_i),
      .ratio_i     (ratio_i),
      .speed_o     (auto_speed),
      .busy_o      (auto_busy)
   );

   // Any 1xx manual code saturates at the fast step
   always_comb begin
      if (drv_tim_q[2]) begin
         manual_speed = txmod_pkg::SPD_FAST; // R14
      end else begin
         manual_speed = {1'b0, drv_tim_q[1:0]}; // R14
      end
   end

   // Passive resistances are used as given; ordering them before passive
   // mode is selected is software's job
   always_comb begin
      if (aux_mod_q[txmod_pkg::DRV_LM_BIT] && passive_target_i) begin
         res_code_d = mod_active_i ? pasv_res_q[7:4] : pasv_res_q[3:0]; // R4 R6 R8
      end else begin
         res_code_d = pasv_res_q[3:0];
      end
   end

   assign loadmod_d = mod_active_i ^ aux_mod_q[txmod_pkg::EXT_POL_BIT]; // R2

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         regulator_am_on_o   <= 1'b0;
         am_depth_index_o    <= txmod_pkg::AM_IDX_RST;
         resistive_am_on_o   <= 1'b0;
         resistive_am_code_o <= txmod_pkg::RAM_CODE_RST;
         driver_res_code_o   <= 4'h0;
         driver_high_z_o     <= 1'b0;
         driver_speed_o      <= txmod_pkg::SPD_FAST;
         ext_loadmod_pin_o   <= 1'b0;
      end else begin
         regulator_am_on_o   <= !aux_mod_q[txmod_pkg::REG_AM_OFF_BIT]; // R1
         am_depth_index_o    <= am_idx_q; // R15
         resistive_am_on_o   <= aux_mod_q[txmod_pkg::RESIST_AM_BIT]; // R5
         resistive_am_code_o <= ram_code_q; // R5 R16
         driver_res_code_o   <= res_code_d;
         driver_high_z_o     <= res_code_d == txmod_pkg::RES_HIGH_Z; // R7
         driver_speed_o      <= drv_tim_q[txmod_pkg::TIM_MAN_BIT] ? manual_speed
                                                                  : auto_speed; // R13
         if (aux_mod_q[txmod_pkg::EXT_EN_BIT]) begin
            ext_loadmod_pin_o <= loadmod_d; // R3
         end else begin
            ext_loadmod_pin_o <= 1'b0; // R3
         end
      end
   end

   property p_reg_am;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> regulator_am_on_o == !$past(aux_mod_q[txmod_pkg::REG_AM_OFF_BIT]);
   endproperty
   a_reg_am: assert property (p_reg_am) else $error("regulator AM enable wrong"); // R1

   property p_ext_pol;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      aux_mod_q[txmod_pkg::EXT_EN_BIT] |=>
         ext_loadmod_pin_o == ($past(mod_active_i) ^ $past(aux_mod_q[txmod_pkg::EXT_POL_BIT]));
   endproperty
   a_ext_pol: assert property (p_ext_pol) else $error("external pin polarity wrong"); // R2

   property p_ext_off;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !aux_mod_q[txmod_pkg::EXT_EN_BIT] |=> !ext_loadmod_pin_o;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("external pin driven when off"); // R3

   property p_drv_lm;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (aux_mod_q[txmod_pkg::DRV_LM_BIT] && passive_target_i && mod_active_i)
         |=> driver_res_code_o == $past(pasv_res_q[7:4]);
   endproperty
   a_drv_lm: assert property (p_drv_lm) else $error("modulated resistance not used"); // R4

   property p_resistive_am_en;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      aux_mod_q[txmod_pkg::RESIST_AM_BIT] |=> resistive_am_on_o
         && resistive_am_code_o == $past(ram_code_q);
   endproperty
   a_resistive_am_en: assert property (p_resistive_am_en) else $error("resistive AM not applied"); // R5

   property p_high_z;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      driver_high_z_o == (driver_res_code_o == txmod_pkg::RES_HIGH_Z);
   endproperty
   a_high_z: assert property (p_high_z) else $error("high impedance decode wrong"); // R7

   property p_manual;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (drv_tim_q[txmod_pkg::TIM_MAN_BIT] && drv_tim_q[2]) |=>
         driver_speed_o == txmod_pkg::SPD_FAST;
   endproperty
   a_manual: assert property (p_manual) else $error("manual fast decode wrong"); // R14

   property p_auto_sel;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !drv_tim_q[txmod_pkg::TIM_MAN_BIT] |=> driver_speed_o == $past(auto_speed);
   endproperty
   a_auto_sel: assert property (p_auto_sel) else $error("automatic timing not selected"); // R13

   property p_reserved;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      aux_mod_q[2:0] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set"); // R17

   property p_unmod_res;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (aux_mod_q[txmod_pkg::DRV_LM_BIT] && passive_target_i && !mod_active_i)
         |=> driver_res_code_o == $past(pasv_res_q[3:0]);
   endproperty
   a_unmod_res: assert property (p_unmod_res) else $error("unmodulated code wrong"); // R6

   property p_lm_off;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!aux_mod_q[txmod_pkg::DRV_LM_BIT] || !passive_target_i)
         |=> driver_res_code_o == $past(pasv_res_q[3:0]);
   endproperty
   a_lm_off: assert property (p_lm_off) else $error("load modulation code wrong"); // R4

   property p_high_z_on;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (res_code_d == txmod_pkg::RES_HIGH_Z) |=> driver_high_z_o;
   endproperty
   a_high_z_on: assert property (p_high_z_on) else $error("high impedance not set"); // R7

   property p_am_depth;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> am_depth_index_o == $past(am_idx_q);
   endproperty
   a_am_depth: assert property (p_am_depth) else $error("AM depth index wrong"); // R15

   property p_res_code;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      1'b1 |=> resistive_am_code_o == $past(ram_code_q);
   endproperty
   a_res_code: assert property (p_res_code) else $error("resistive code wrong"); // R16

   property p_resistive_am_en_off;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !aux_mod_q[txmod_pkg::RESIST_AM_BIT] |=> !resistive_am_on_o;
   endproperty
   a_resistive_am_en_off: assert property (p_resistive_am_en_off) else $error("resistive AM not off"); // R5

   property p_manual_low;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (drv_tim_q[txmod_pkg::TIM_MAN_BIT] && !drv_tim_q[2])
         |=> driver_speed_o == {1'b0, $past(drv_tim_q[1:0])};
   endproperty
   a_manual_low: assert property (p_manual_low) else $error("manual speed decode wrong"); // R14

   property p_manual_sel;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      drv_tim_q[txmod_pkg::TIM_MAN_BIT] |=> driver_speed_o == $past(manual_speed);
   endproperty
   a_manual_sel: assert property (p_manual_sel) else $error("manual timing not used"); // R13

   // Register file checks: writes land whole, reserved bits stay clear
   property p_aux_write;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && wb_we_i && wb_sel_i[0] && hit_aux)
         |=> aux_mod_q == ($past(wb_dat_i[7:0]) & txmod_pkg::AUX_MOD_MASK);
   endproperty
   a_aux_write: assert property (p_aux_write) else $error("aux write wrong"); // R17

   property p_tim_write;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && wb_we_i && wb_sel_i[0] && hit_tim)
         |=> drv_tim_q == $past(wb_dat_i[7:0]);
   endproperty
   a_tim_write: assert property (p_tim_write) else $error("timing write wrong"); // R9

   property p_pas_write;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && wb_we_i && wb_sel_i[0] && hit_pt)
         |=> pasv_res_q == $past(wb_dat_i[7:0]);
   endproperty
   a_pas_write: assert property (p_pas_write) else $error("passive write wrong"); // R6

   property p_aux_read;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && !wb_we_i && hit_aux) |=> wb_dat_o == {24'h00_0000, $past(aux_mod_q)};
   endproperty
   a_aux_read: assert property (p_aux_read) else $error("aux read wrong"); // R17

   property p_lane_only;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && wb_we_i && !wb_sel_i[0]) |=> $stable(aux_mod_q) && $stable(pasv_res_q)
         && $stable(drv_tim_q) && $stable(am_idx_q) && $stable(ram_code_q);
   endproperty
   a_lane_only: assert property (p_lane_only) else $error("write without lane 0"); // R9

   property p_target_top;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (auto_busy && rf_period_i && ratio_i >= drv_tim_q[7:4]) |=> !auto_busy;
   endproperty
   a_target_top: assert property (p_target_top) else $error("target not honoured"); // R9

   property p_status_read;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && !wb_we_i && hit_stat)
         |=> wb_dat_o == {24'h00_0000, 4'h0, $past(auto_busy), $past(driver_speed_o)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // R11
endmodule
`default_nettype wire

// >>> tb_tx_modulation_driver_config.sv
// Self-checking bench for the transmitter modulation configuration bank
`default_nettype none
module tb_tx_modulation_driver_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i;
   logic        rst_n_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        wb_err_o;
   logic        mod_active_i;
   logic        passive_target_i;
   logic        auto_start_i;
   logic        rf_period_i;
   logic [3:0]  ratio_i;
   logic        regulator_am_on_o;
   logic [3:0]  am_depth_index_o;
   logic        resistive_am_on_o;
   logic [6:0]  resistive_am_code_o;
   logic [3:0]  driver_res_code_o;
   logic        driver_high_z_o;
   logic [2:0]  driver_speed_o;
   logic        ext_loadmod_pin_o;
   int          failures;
   int          comparisons;
   logic [31:0] rd;
   logic        err;
   logic [9:0]  radr [5];
   logic [7:0]  rexp [5];
   logic [9:0]  pin_tab [6];
   logic [12:0] res_tab [3];

   txmod_config i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .mod_active_i(mod_active_i), .passive_target_i(passive_target_i),
      .auto_start_i(auto_start_i), .rf_period_i(rf_period_i), .ratio_i(ratio_i),
      .regulator_am_on_o(regulator_am_on_o), .am_depth_index_o(am_depth_index_o),
      .resistive_am_on_o(resistive_am_on_o), .resistive_am_code_o(resistive_am_code_o),
      .driver_res_code_o(driver_res_code_o), .driver_high_z_o(driver_high_z_o),
      .driver_speed_o(driver_speed_o), .ext_loadmod_pin_o(ext_loadmod_pin_o)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Outputs are looked at on the falling edge, well clear of register updates
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                          input logic [31:0] wdat);
      int n = 0;
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wdat;
      // Ack and read data are taken at the rising edge that samples ack high
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      rd  = wb_dat_o;
      err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
         check(32'(wb_ack_o | wb_err_o), 32'h1);
         summarize();
      end
   endtask

   task automatic wr(input logic [9:0] adr, input logic [7:0] d);
      wb_xfer(1'b1, adr, 4'hf, 32'(d));
   endtask

   task automatic rdreg(input logic [9:0] adr);
      wb_xfer(1'b0, adr, 4'hf, 32'h0);
   endtask

   task automatic pulse(input logic start, input logic [3:0] r);
      @(posedge clk_sys_i);
      auto_start_i <= start;
      rf_period_i  <= ~start;
      ratio_i      <= r;
      @(posedge clk_sys_i);
      auto_start_i <= 1'b0;
      rf_period_i  <= 1'b0;
      tick(2);
   endtask

   initial begin
      failures = 0;
      comparisons = 0;
      rst_n_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 10'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      mod_active_i = 1'b0;
      passive_target_i = 1'b0;
      auto_start_i = 1'b0;
      rf_period_i = 1'b0;
      ratio_i = 4'h0;
      radr = '{txmod_pkg::AUX_MOD_ADDR, txmod_pkg::PASV_RES_ADDR, txmod_pkg::DRV_TIM_ADDR,
               txmod_pkg::AM_IDX_ADDR, txmod_pkg::RAM_CODE_ADDR};
      rexp = '{8'h10, 8'h70, 8'h7c, 8'h07, 8'h00};
      // Entries: aux value, modulated state, expected pin level
      pin_tab = '{{8'h20, 2'b11}, {8'h20, 2'b00}, {8'h60, 2'b01}, {8'h60, 2'b10},
                  {8'h40, 2'b00}, {8'h40, 2'b10}};
      // Entries: aux value, modulated state, expected resistance code
      res_tab = '{{8'h10, 1'b1, 4'hf}, {8'h10, 1'b0, 4'h3}, {8'h00, 1'b1, 4'h3}};
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      tick(2);
      check(32'(regulator_am_on_o), 32'h1);
      check(32'(am_depth_index_o), 32'h7);
      check(32'(driver_speed_o), 32'(txmod_pkg::SPD_FAST));
      for (int i = 0; i < 5; i++) begin
         rdreg(radr[i]);
         check(rd, 32'(rexp[i]));
      end
      $display("test reset values done");
      wr(txmod_pkg::AUX_MOD_ADDR, 8'hff);
      rdreg(txmod_pkg::AUX_MOD_ADDR);
      check(rd, 32'hf8);
      wr(txmod_pkg::RAM_CODE_ADDR, 8'h55);
      wr(txmod_pkg::AM_IDX_ADDR, 8'h0f);
      wb_xfer(1'b1, txmod_pkg::AM_IDX_ADDR, 4'he, 32'h3);
      tick(2);
      check(32'(regulator_am_on_o), 32'h0);
      check(32'(resistive_am_on_o), 32'h1);
      check(32'(resistive_am_code_o), 32'h55);
      check(32'(am_depth_index_o), 32'hf);
      wb_xfer(1'b0, 10'h000, 4'hf, 32'h0);
      check(32'(err), 32'h1);
      $display("test modulation fields done");
      for (int i = 0; i < 6; i++) begin
         wr(txmod_pkg::AUX_MOD_ADDR, pin_tab[i][9:2]);
         @(posedge clk_sys_i);
         mod_active_i <= pin_tab[i][1];
         tick(2);
         check(32'(ext_loadmod_pin_o), 32'(pin_tab[i][0]));
      end
      $display("test external pin done");
      wr(txmod_pkg::PASV_RES_ADDR, 8'hf3);
      passive_target_i <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(txmod_pkg::AUX_MOD_ADDR, res_tab[i][12:5]);
         @(posedge clk_sys_i);
         mod_active_i <= res_tab[i][4];
         tick(2);
         check(32'(driver_res_code_o), 32'(res_tab[i][3:0]));
         check(32'(driver_high_z_o), 32'(res_tab[i][3:0] == 4'hf));
      end
      $display("test passive resistance done");
      for (int c = 0; c < 8; c++) begin
         wr(txmod_pkg::DRV_TIM_ADDR, {5'h0f, 3'(c)});
         tick(2);
         check(32'(driver_speed_o), (c > 3) ? 32'h4 : 32'(c));
      end
      $display("test manual timing done");
      // Target of three, automatic source
      wr(txmod_pkg::DRV_TIM_ADDR, 8'h30);
      pulse(1'b1, 4'h0);
      check(32'(driver_speed_o), 32'(txmod_pkg::SPD_SLOW));
      rdreg(txmod_pkg::STATUS_ADDR);
      check(rd, 32'h08);
      pulse(1'b0, 4'h1);
      check(32'(driver_speed_o), 32'h1);
      pulse(1'b0, 4'h2);
      check(32'(driver_speed_o), 32'h2);
      pulse(1'b0, 4'h3);
      check(32'(driver_speed_o), 32'h2);
      rdreg(txmod_pkg::STATUS_ADDR);
      check(rd, 32'h02);
      pulse(1'b1, 4'h0);
      for (int k = 1; k <= 6; k++) begin
         pulse(1'b0, 4'h0);
         check(32'(driver_speed_o), (k > 4) ? 32'h4 : 32'(k));
      end
      rdreg(txmod_pkg::STATUS_ADDR);
      check(rd, 32'h04);
      $display("test automatic timing done");
      summarize();
   end
endmodule
`default_nettype wire
